/* rtl/dac_serial_write_port_map.svh */
// constants of the serial write port of a single-channel voltage-output converter
// assumes it is included by bare name from rtl/ and defines macros only
// What this block does
// - sample serial data into the shift register on each falling serial clock edge up to the 24th or 16th of a frame
// - frame sync is active low; while low the shift register stays enabled
// - only falling edges after frame sync falls are taken as data bits
// - update the output after the 24th or 16th clock of a frame
// - frame sync rising before the last edge aborts; output keeps its value
// - output is zero from power-on until the first complete frame
`ifndef DAC_SERIAL_WRITE_PORT_MAP_SVH
`define DAC_SERIAL_WRITE_PORT_MAP_SVH

// ==========================================================
// word lengths of the two variants
`define DSWP_WORD_BITS_WIDE   24
`define DSWP_WORD_BITS_NARROW 16

// ==========================================================
// reset values
`define DSWP_OUTPUT_RESET     1'h0
`define DSWP_TOGGLE_RESET     1'h0

// ==========================================================
// timing
`define DSWP_CLK_PERIOD_NS    50
`define DSWP_SCLK_MAX_MHZ     50
`define DSWP_SCLK_MIN_PERIOD_NS (1000 / `DSWP_SCLK_MAX_MHZ)
`define DSWP_SETTLE_NS        150
`define DSWP_SETTLE_CYCLES    ((`DSWP_SETTLE_NS + `DSWP_CLK_PERIOD_NS - 1) / `DSWP_CLK_PERIOD_NS)

`endif

/* rtl/dac_serial_write_port_pkg.sv */
// types used by the serial write port for its frame tracker
// assumes nothing beyond the map header
package dac_serial_write_port_pkg;

  // ==========================================================
  // frame tracking in the system clock domain
  typedef enum logic [2:0] {
    st_idle   = 3'h1,
    st_frame  = 3'h2,
    st_settle = 3'h4
  } frame_state_t;

  typedef logic [2:0] settle_count_t;

endpackage

/* rtl/level_sync2.sv */
// two-flop synchroniser for one level from a foreign domain
// assumes the input changes no faster than two clk periods
`timescale 1ns/1ps
`default_nettype none
module level_sync2 (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // level in and out
  input  wire logic async_in,
  output var  logic sync_out
);

  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= 1'h0;
      sync_out <= 1'h0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule
`default_nettype wire

/* rtl/toggle_word_handoff.sv */
// toggle handshake that carries a held word into the clk domain
// assumes the source holds the word steady from its toggle until the next toggle
`timescale 1ns/1ps
`default_nettype none
module toggle_word_handoff #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // source side
  input  wire logic         src_toggle,
  input  wire logic [W-1:0] src_word,
  // destination side
  output logic              dst_pulse,
  output var  logic [W-1:0] dst_word
);

  logic         toggle_sync;
  logic         toggle_seen;
  logic         next_toggle_seen;
  logic [W-1:0] next_dst_word;

  if (W < 1) begin : g_bad_width
    $error("toggle_word_handoff: W must be at least 1");
  end

  level_sync2 u_toggle_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (src_toggle),
    .sync_out (toggle_sync)
  );

  // the word is read only after the toggle has settled, so it is stable here
  assign dst_pulse = toggle_sync ^ toggle_seen;

  always_comb begin
    next_toggle_seen = toggle_sync;
    next_dst_word    = dst_pulse ? src_word : dst_word;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_seen <= 1'h0;
      dst_word    <= '0;
    end else begin
      toggle_seen <= next_toggle_seen;
      dst_word    <= next_dst_word;
    end
  end

endmodule
`default_nettype wire

/* rtl/dac_serial_write_port.sv */
// serial write port: shift logic on the serial clock, output register on clk
// assumes the host drives frame sync, serial clock and data, and keeps the
// serial clock still while frame sync changes
`timescale 1ns/1ps
`default_nettype none
`include "dac_serial_write_port_map.svh"
module dac_serial_write_port
  import dac_serial_write_port_pkg::*;
#(
  parameter bit WIDE_VARIANT = 1'b1,
  parameter int CNT_W        = 16,
  localparam int WORD_W      = WIDE_VARIANT ? `DSWP_WORD_BITS_WIDE : `DSWP_WORD_BITS_NARROW
) (
  // system clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // serial link from the host
  input  wire logic              sclk,
  input  wire logic              frame_sync_b,
  input  wire logic              serial_data,
  // converter code
  output var  logic [WORD_W-1:0] analog_output,
  output var  logic              output_loaded,
  // status
  output var  logic              frame_active,
  output var  logic              update_pulse,
  output var  logic              abort_pulse,
  output var  logic              overlong_pulse,
  output var  logic [CNT_W-1:0]  update_count,
  output var  logic [CNT_W-1:0]  abort_count,
  output var  logic [CNT_W-1:0]  overlong_count
);

  // ==========================================================
  // elaboration checks
  localparam int BIT_W = $clog2(WORD_W + 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_W - 1);
  localparam logic [BIT_W-1:0] FULL_BIT = BIT_W'(WORD_W);
  localparam int SETTLE_N = `DSWP_SETTLE_CYCLES;
  localparam settle_count_t SETTLE_LOAD = settle_count_t'(SETTLE_N - 1);

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("dac_serial_write_port: CNT_W must be 1 to 32");
  end
  if (SETTLE_N < 1 || SETTLE_N > 8) begin : g_bad_settle
    $error("dac_serial_write_port: settle count out of range");
  end
  // the host keeps sclk period at or above this; the handoff relies on a
  // whole frame lasting longer than the three clk cycles of the crossing
  if (WORD_W * `DSWP_SCLK_MIN_PERIOD_NS < 3 * `DSWP_CLK_PERIOD_NS) begin : g_bad_rate
    $error("dac_serial_write_port: frame too short for the word crossing");
  end

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input logic en);
    bump = en ? CNT_W'(v + 1'b1) : v;
  endfunction

  // ==========================================================
  // link domain: frame-scoped shift state
  logic              link_run_b;
  logic [BIT_W-1:0]  bit_count;
  logic [BIT_W-1:0]  next_bit_count;
  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] next_shift_word;
  logic [WORD_W-1:0] shifted;
  logic              extra_seen;
  logic              next_extra_seen;
  logic              last_edge;
  logic              extra_edge;

  // frame sync high holds the shift state in reset; sclk is idle when it
  // falls, so the release never races a capturing edge
  assign link_run_b = rst_b & ~frame_sync_b;

  assign shifted    = {shift_word[WORD_W-2:0], serial_data};
  assign last_edge  = (bit_count == LAST_BIT);
  assign extra_edge = (bit_count == FULL_BIT);

  always_comb begin
    next_bit_count  = bit_count;
    next_shift_word = shift_word;
    next_extra_seen = extra_seen;
    if (bit_count < FULL_BIT) begin
      next_shift_word = shifted;
      next_bit_count  = BIT_W'(bit_count + 1'b1);
    end else begin
      // clocks beyond a full word are ignored until the next frame
      next_extra_seen = 1'h1;
    end
  end

  always_ff @(negedge sclk or negedge link_run_b) begin
    if (!link_run_b) begin
      bit_count  <= '0;
      shift_word <= '0;
      extra_seen <= 1'h0;
    end else begin
      bit_count  <= next_bit_count;
      shift_word <= next_shift_word;
      extra_seen <= next_extra_seen;
    end
  end

  // ==========================================================
  // link domain: state that outlives the frame
  logic [WORD_W-1:0] held_word;
  logic [WORD_W-1:0] next_held_word;
  logic              word_toggle;
  logic              next_word_toggle;
  logic              overlong_toggle;
  logic              next_overlong_toggle;

  // an aborted frame never reaches the last edge, so nothing is handed on
  always_comb begin
    next_held_word       = held_word;
    next_word_toggle     = word_toggle;
    next_overlong_toggle = overlong_toggle;
    if (!frame_sync_b && last_edge) begin
      next_held_word   = shifted;
      next_word_toggle = ~word_toggle;
    end
    if (!frame_sync_b && extra_edge && !extra_seen) begin
      next_overlong_toggle = ~overlong_toggle;
    end
  end

  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      held_word       <= '0;
      word_toggle     <= `DSWP_TOGGLE_RESET;
      overlong_toggle <= `DSWP_TOGGLE_RESET;
    end else begin
      held_word       <= next_held_word;
      word_toggle     <= next_word_toggle;
      overlong_toggle <= next_overlong_toggle;
    end
  end

  // ==========================================================
  // crossings into clk
  logic              word_pulse;
  logic [WORD_W-1:0] word_in;
  logic              sync_high;
  logic              overlong_sync;
  logic              overlong_seen;
  logic              next_overlong_seen;
  logic              frame_low;

  toggle_word_handoff #(
    .W (WORD_W)
  ) u_word_handoff (
    .clk        (clk),
    .rst_b      (rst_b),
    .src_toggle (word_toggle),
    .src_word   (held_word),
    .dst_pulse  (word_pulse),
    .dst_word   (word_in)
  );

  level_sync2 u_frame_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (frame_sync_b),
    .sync_out (sync_high)
  );

  level_sync2 u_overlong_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (overlong_toggle),
    .sync_out (overlong_sync)
  );

  // the synchroniser resets low, which reads as a frame until the pin settles;
  // the frame tracker waits in idle for a clean rise first
  assign frame_low = ~sync_high;

  // ==========================================================
  // converter code register
  logic [WORD_W-1:0] next_analog_output;
  logic              next_output_loaded;
  logic              word_ready;
  logic              next_word_ready;

  // the handoff registers its word on the pulse edge, so loading on the
  // pulse itself would take the previous frame's word; wait one cycle
  always_comb begin
    next_word_ready    = word_pulse;
    next_analog_output = analog_output;
    next_output_loaded = output_loaded;
    if (word_ready) begin
      next_analog_output = word_in;
      next_output_loaded = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_ready    <= 1'h0;
      analog_output <= {WORD_W{`DSWP_OUTPUT_RESET}};
      output_loaded <= 1'h0;
    end else begin
      word_ready    <= next_word_ready;
      analog_output <= next_analog_output;
      output_loaded <= next_output_loaded;
    end
  end

  // ==========================================================
  // frame tracker: tells completed frames from aborted ones
  frame_state_t  state;
  frame_state_t  next_state;
  settle_count_t settle;
  settle_count_t next_settle;
  logic          got_word;
  logic          next_got_word;
  logic          armed;
  logic          next_armed;
  logic          word_update;
  logic          next_update_pulse;
  logic          next_abort_pulse;
  logic          next_frame_active;

  // the update pulse rises with the load; the settle delay gives the word
  // crossing and its load stage time to report before the abort check
  assign word_update = word_ready;

  always_comb begin
    next_state        = state;
    next_settle       = settle;
    next_got_word     = got_word | word_update;
    next_armed        = armed | sync_high;
    next_update_pulse = word_update;
    next_abort_pulse  = 1'h0;
    next_frame_active = frame_low & armed;
    unique case (state)
      st_idle: begin
        next_got_word = 1'h0;
        if (frame_low && armed) begin
          next_state = st_frame;
        end
      end
      st_frame: begin
        if (!frame_low) begin
          next_state  = st_settle;
          next_settle = SETTLE_LOAD;
        end
      end
      st_settle: begin
        if (settle == '0) begin
          // no word by now means frame sync rose early
          next_abort_pulse = ~(got_word | word_update);
          next_got_word    = 1'h0;
          next_state       = frame_low ? st_frame : st_idle;
        end else begin
          next_settle = settle_count_t'(settle - 1'b1);
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= st_idle;
      settle       <= '0;
      got_word     <= 1'h0;
      armed        <= 1'h0;
      update_pulse <= 1'h0;
      abort_pulse  <= 1'h0;
      frame_active <= 1'h0;
    end else begin
      state        <= next_state;
      settle       <= next_settle;
      got_word     <= next_got_word;
      armed        <= next_armed;
      update_pulse <= next_update_pulse;
      abort_pulse  <= next_abort_pulse;
      frame_active <= next_frame_active;
    end
  end

  // ==========================================================
  // overlong frames and event counters
  logic             overlong_event;
  logic             next_overlong_pulse;
  logic [CNT_W-1:0] next_update_count;
  logic [CNT_W-1:0] next_abort_count;
  logic [CNT_W-1:0] next_overlong_count;

  assign overlong_event = overlong_sync ^ overlong_seen;

  // counters wrap; software-free so nothing ever clears them but reset
  always_comb begin
    next_overlong_seen  = overlong_sync;
    next_overlong_pulse = overlong_event;
    next_update_count   = bump(update_count, update_pulse);
    next_abort_count    = bump(abort_count, abort_pulse);
    next_overlong_count = bump(overlong_count, overlong_pulse);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overlong_seen  <= 1'h0;
      overlong_pulse <= 1'h0;
      update_count   <= '0;
      abort_count    <= '0;
      overlong_count <= '0;
    end else begin
      overlong_seen  <= next_overlong_seen;
      overlong_pulse <= next_overlong_pulse;
      update_count   <= next_update_count;
      abort_count    <= next_abort_count;
      overlong_count <= next_overlong_count;
    end
  end

endmodule
`default_nettype wire

/* verif/dac_serial_write_port_asserts.sv */
// checker for the serial write port, system clock side only
// assumes it is bound onto dac_serial_write_port and sees its ports alone
`timescale 1ns/1ps
`default_nettype none
`include "dac_serial_write_port_map.svh"
module dac_serial_write_port_asserts #(
  parameter bit WIDE_VARIANT = 1'b1,
  parameter int CNT_W        = 16,
  localparam int WORD_W      = WIDE_VARIANT ? `DSWP_WORD_BITS_WIDE : `DSWP_WORD_BITS_NARROW
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // serial link
  input wire logic              sclk,
  input wire logic              frame_sync_b,
  input wire logic              serial_data,
  // outputs under watch
  input wire logic [WORD_W-1:0] analog_output,
  input wire logic              output_loaded,
  input wire logic              frame_active,
  input wire logic              update_pulse,
  input wire logic              abort_pulse,
  input wire logic              overlong_pulse,
  input wire logic [CNT_W-1:0]  update_count,
  input wire logic [CNT_W-1:0]  abort_count,
  input wire logic [CNT_W-1:0]  overlong_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // assertions
  property p_zero_until_loaded; !output_loaded |-> analog_output == '0; endproperty
  a_zero_until_loaded: assert property (p_zero_until_loaded) else $error("output not zero before load");
  property p_change_pulses; $changed(analog_output) |-> update_pulse; endproperty
  a_change_pulses: assert property (p_change_pulses) else $error("output change without update pulse");
  property p_upd_single; update_pulse |-> output_loaded ##1 !update_pulse; endproperty
  a_upd_single: assert property (p_upd_single) else $error("update pulse malformed");
  property p_upd_count; update_pulse |=> update_count == $past(update_count) + 1'b1; endproperty
  a_upd_count: assert property (p_upd_count) else $error("update count not advanced");
  property p_upd_hold; !update_pulse |=> update_count == $past(update_count); endproperty
  a_upd_hold: assert property (p_upd_hold) else $error("update count moved without pulse");
  property p_abort_keeps; abort_pulse |-> $stable(analog_output) && !update_pulse; endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed the output");
  property p_abort_count; abort_pulse |=> abort_count == $past(abort_count) + 1'b1; endproperty
  a_abort_count: assert property (p_abort_count) else $error("abort count not advanced");
  property p_ovl_count; overlong_pulse |=> overlong_count == $past(overlong_count) + 1'b1; endproperty
  a_ovl_count: assert property (p_ovl_count) else $error("overlong count not advanced");
  property p_idle_inactive; frame_sync_b [*4] |=> !frame_active; endproperty
  a_idle_inactive: assert property (p_idle_inactive) else $error("frame active while sync high");
  property p_low_active; (!frame_sync_b) [*6] |-> frame_active; endproperty
  a_low_active: assert property (p_low_active) else $error("frame not active while sync low");
  // ==========================================================
  // coverage
  c_update: cover property (update_pulse);
  c_abort: cover property (abort_pulse);
  c_overlong: cover property (overlong_pulse);
endmodule
bind dac_serial_write_port dac_serial_write_port_asserts #(
  .WIDE_VARIANT (WIDE_VARIANT),
  .CNT_W        (CNT_W)
) u_asserts (.*);
`default_nettype wire

/* verif/dac_serial_host_model.sv */
// host side of the serial link: frame sync, serial clock and data
// assumes tasks are called from the bench one at a time
`timescale 1ns/1ps
`default_nettype none
module dac_serial_host_model (
  // serial link outputs
  output var logic sclk,
  output var logic frame_sync_b,
  output var logic serial_data
);
  initial begin
    sclk = 1'b1;
    frame_sync_b = 1'b1;
    serial_data = 1'b0;
  end
  // ==========================================================
  // one frame, bits taken from bit 31 downwards; half is in ns
  task automatic send(input logic [31:0] bits, input int n, input int half);
    int i;
    frame_sync_b = 1'b0;
    #(half);
    for (i = 0; i < n; i++) begin
      serial_data = bits[31-i];
      #(half);
      sclk = 1'b0;
      #(half);
      sclk = 1'b1;
    end
    #(half);
    frame_sync_b = 1'b1;
    // released line must not keep showing the last bit
    serial_data = ~serial_data;
    #200;
  endtask
  // stray clocks with sync high, which must not be taken
  task automatic stray(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      serial_data = i[0];
      #32;
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
    end
    #200;
  endtask
endmodule
`default_nettype wire

/* verif/dac_serial_write_port_tb_top.sv */
// self-checking bench for the serial write port, wide variant
// assumes the host model drives the link and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_tb_top;
  logic        clk;
  logic        rst_b;
  wire logic   sclk;
  wire logic   frame_sync_b;
  wire logic   serial_data;
  logic [23:0] analog_output;
  logic        output_loaded;
  logic        frame_active;
  logic        update_pulse;
  logic        abort_pulse;
  logic        overlong_pulse;
  logic [15:0] update_count;
  logic [15:0] abort_count;
  logic [15:0] overlong_count;
  logic [15:0] n_upd;
  logic [15:0] n_abt;
  logic [15:0] n_ovl;
  int          fail_count;
  int          num_checks;

  dac_serial_write_port #(.WIDE_VARIANT(1'b1), .CNT_W(16)) u_dut (
    .clk            (clk),
    .rst_b          (rst_b),
    .sclk           (sclk),
    .frame_sync_b   (frame_sync_b),
    .serial_data    (serial_data),
    .analog_output  (analog_output),
    .output_loaded  (output_loaded),
    .frame_active   (frame_active),
    .update_pulse   (update_pulse),
    .abort_pulse    (abort_pulse),
    .overlong_pulse (overlong_pulse),
    .update_count   (update_count),
    .abort_count    (abort_count),
    .overlong_count (overlong_count)
  );
  dac_serial_host_model u_host (.sclk(sclk), .frame_sync_b(frame_sync_b), .serial_data(serial_data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // shared checks
  task automatic end_sim();
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // bounded wait until all three event counters reach their expected values
  task automatic wait_counts();
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk);
      if (update_count === n_upd && abort_count === n_abt && overlong_count === n_ovl) break;
    end
    num_checks++;
    if (i == 60) begin
      fail_count++;
      $display("unexpected counts: expected %h %h %h, seen %h %h %h",
               n_upd, n_abt, n_ovl, update_count, abort_count, overlong_count);
      end_sim();
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic frame_ok(input logic [23:0] w, input int half);
    u_host.send({w, 8'h00}, 24, half);
    n_upd++;
    wait_counts();
    check("analog_output", w, analog_output);
    check("output_loaded", 24'h00_0001, {23'h0, output_loaded});
  endtask
  task automatic frame_abort(input int n, input logic [23:0] keep);
    u_host.send(32'hFFFF_FFFF, n, 32);
    n_abt++;
    wait_counts();
    check("analog_output", keep, analog_output);
  endtask
  task automatic frame_long(input logic [23:0] w);
    u_host.send({w, 8'hC0}, 26, 32);
    n_upd++;
    n_ovl++;
    wait_counts();
    check("analog_output", w, analog_output);
  endtask

  initial begin
    rst_b = 1'b0;
    n_upd = 16'h0000;
    n_abt = 16'h0000;
    n_ovl = 16'h0000;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check("analog_output", 24'h00_0000, analog_output);
    #13;
    frame_abort(10, 24'h00_0000);
    check("output_loaded", 24'h00_0000, {23'h0, output_loaded});
    frame_ok(24'hA5_C3_17, 32);
    frame_abort(23, 24'hA5_C3_17);
    frame_ok(24'h12_3456, 32);
    u_host.stray(5);
    frame_ok(24'hFE_DCBA, 32);
    frame_long(24'h5A_0F_81);
    frame_ok(24'h00_0000, 32);
    end_sim();
  end
endmodule
`default_nettype wire
